// [core/acmp_top.sv]
// Comparator control, status and interrupt logic with AXI4-Lite registers
//
// Summary of operation
// - Result high while positive exceeds negative input
// - Power-off bit 7 switches comparator off
// - Bit 6 selects bandgap onto positive input
// - Bit 6 reads zero without bandgap option
// - Bit 2 reserved, always reads zero
// - Bit 5 reads live comparator result
// - Matching output event sets flag bit 4
// - Request needs flag, enable and global enable
// - Vector entry clears the interrupt flag
// - Writing one clears flag, zero keeps it
// - Bit 3 enables the comparator interrupt
// - Mode bits: toggle, reserved, falling, rising
// - Reference powered by brown-out or bandgap select
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`include "acmp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module acmp_top #(
  parameter int VW = 10,
  parameter logic HAS_BANDGAP = 1'b1,
  parameter logic [VW-1:0] BG_CODE = '0,
  parameter int REF_START_CYC = `ACMP_REF_START_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [`ACMP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ACMP_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [VW-1:0] positive_input_i,
  input wire logic [VW-1:0] negative_input_i,
  input wire logic brownout_enable_fuse_i,
  input wire logic global_irq_en_i,
  input wire logic irq_vector_ack_i,
  output logic comparator_irq_req_o,
  output logic irq_o,
  output logic comp_power_o,
  output logic ref_power_o
);
  import acmp_pkg::*;

  localparam logic [9:0] REF_LAST = 10'(REF_START_CYC - 1);
  localparam logic [7:0] CSR_RST = `ACMP_CSR_RST;

  logic power_off_r;
  logic bg_sel_r;
  logic flag_r;
  logic ien_r;
  acmp_mode_type mode_r;
  logic ref_evt_r;
  logic ref_mask_r;
  logic ref_power_r;
  logic ref_ready_r;
  logic [9:0] ref_cnt_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [`ACMP_ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // Comparator model: forced low while powered off, so the level drops
  // when switched off and may fire an event in toggle or fall mode
  wire bg_active = HAS_BANDGAP & bg_sel_r;
  wire [VW-1:0] pos_sel = bg_active ? BG_CODE : positive_input_i;
  wire comp_raw = ~power_off_r & (pos_sel > negative_input_i);

  wire comp_sync;
  wire comp_evt;

  // Level is re-timed before edge detection
  acmp_sync2 u_sync (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .d_i(comp_raw),
    .q_o(comp_sync)
  );

  // Event per selected mode
  acmp_evdet u_evdet (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .level_i(comp_sync),
    .mode_i(mode_r),
    .event_o(comp_evt)
  );

  // Write path: both halves are held, then applied in one cycle
  wire wr_go = aw_hold_r & w_hold_r & ~bvalid_r;
  wire [5:0] wr_idx = awaddr_r[`ACMP_ADDR_W-1:2];
  wire wr_csr = wr_idx == `ACMP_CSR_OFS >> 2;
  wire wr_stat = wr_idx == `ACMP_STAT_OFS >> 2;
  wire wr_mask = wr_idx == `ACMP_MASK_OFS >> 2;
  wire wr_ref = wr_idx == `ACMP_REF_OFS >> 2;
  wire wr_hit = wr_csr | wr_stat | wr_mask | wr_ref;
  wire wr_en = wr_go & wstrb0_r;
  wire csr_we = wr_en & wr_csr;
  wire mask_we = wr_en & wr_mask;
  wire flag_w1c = wr_en & ((wr_csr & wdata_r[`ACMP_B_FLAG]) |
                  (wr_stat & wdata_r[`ACMP_B_STAT_CMP]));
  wire ref_w1c = wr_en & wr_stat & wdata_r[`ACMP_B_STAT_REF];

  assign s_axi_awready = ~aw_hold_r;
  assign s_axi_wready = ~w_hold_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // AXI write channel holds and response
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `ACMP_RESP_OK;
    end else begin
      if (s_axi_awvalid && !aw_hold_r) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && !w_hold_r) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `ACMP_RESP_OK : `ACMP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Control fields; bandgap bit sticks at zero on the small variant
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      power_off_r <= CSR_RST[`ACMP_B_OFF];
      bg_sel_r <= 1'b0;
      ien_r <= 1'b0;
      mode_r <= ACMP_MODE_TOGGLE;
      ref_mask_r <= 1'b0;
    end else if (csr_we) begin
      power_off_r <= wdata_r[`ACMP_B_OFF];
      bg_sel_r <= HAS_BANDGAP & wdata_r[`ACMP_B_BG];
      ien_r <= wdata_r[`ACMP_B_IEN];
      mode_r <= acmp_mode_type'(wdata_r[1:0]);
    end else if (mask_we) begin
      ien_r <= wdata_r[`ACMP_B_STAT_CMP];
      ref_mask_r <= wdata_r[`ACMP_B_STAT_REF];
    end
  end

  // Sticky flags: a new event beats a same-cycle clear
  wire flag_nxt = comp_evt |
                  (flag_r & ~flag_w1c & ~irq_vector_ack_i);
  wire ref_done = ref_power_r & ~ref_ready_r & (ref_cnt_r == REF_LAST);
  wire ref_evt_nxt = ref_done | (ref_evt_r & ~ref_w1c);
  wire ref_power_nxt = brownout_enable_fuse_i | bg_active;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      flag_r <= 1'b0;
      ref_evt_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      ref_evt_r <= ref_evt_nxt;
    end
  end

  // Reference start-up timer; restarts whenever the reference drops
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ref_power_r <= 1'b0;
      ref_ready_r <= 1'b0;
      ref_cnt_r <= '0;
    end else begin
      ref_power_r <= ref_power_nxt;
      ref_ready_r <= ref_power_r & (ref_ready_r | ref_done);
      if (!ref_power_r) begin
        ref_cnt_r <= '0;
      end else if (!ref_ready_r) begin
        ref_cnt_r <= ref_cnt_r + 10'h001;
      end
    end
  end

  // Read mux; result bit is the live comparator, not a latched copy
  wire [7:0] csr_rd = {power_off_r, bg_active, comp_raw, flag_r,
                       ien_r, 1'b0, mode_r};
  wire [7:0] stat_rd = {6'h00, ref_evt_r, flag_r};
  wire [7:0] mask_rd = {6'h00, ref_mask_r, ien_r};
  wire [7:0] ref_rd = {6'h00, ref_ready_r, ref_power_r};
  wire [5:0] rd_idx = s_axi_araddr[`ACMP_ADDR_W-1:2];
  wire rd_csr = rd_idx == `ACMP_CSR_OFS >> 2;
  wire rd_stat = rd_idx == `ACMP_STAT_OFS >> 2;
  wire rd_mask = rd_idx == `ACMP_MASK_OFS >> 2;
  wire rd_ref = rd_idx == `ACMP_REF_OFS >> 2;
  wire rd_hit = rd_csr | rd_stat | rd_mask | rd_ref;
  wire [7:0] rd_byte = rd_csr ? csr_rd : rd_stat ? stat_rd :
                       rd_mask ? mask_rd : rd_ref ? ref_rd : 8'h00;
  wire rd_go = s_axi_arvalid & ~rvalid_r;

  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Read channel: one outstanding read, data captured at accept
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `ACMP_RESP_OK;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, rd_byte};
      rresp_r <= rd_hit ? `ACMP_RESP_OK : `ACMP_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Interrupt outputs; combinational so vector entry sees no lag
  assign comparator_irq_req_o = flag_r & ien_r & global_irq_en_i;
  assign irq_o = comparator_irq_req_o | (ref_evt_r & ref_mask_r);
  assign comp_power_o = ~power_off_r;
  assign ref_power_o = ref_power_r;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_raw_rise;
    $rose(comp_raw) ##1 comp_raw;
  endsequence

  sequence s_ack_no_evt;
    irq_vector_ack_i && !comp_evt;
  endsequence

  chk_off_result_low: assert property (
    power_off_r |-> !comp_raw)
    else $error("comparator result high while powered off");

  chk_sync_two_stage: assert property (
    s_raw_rise |-> ##1 comp_sync)
    else $error("synchronised level not high two cycles after rise");

  chk_event_sets_flag: assert property (
    comp_evt |=> flag_r)
    else $error("event did not set the flag");

  chk_vector_ack_clear: assert property (
    s_ack_no_evt |=> !flag_r)
    else $error("flag not cleared on vector entry");

  chk_write_zero_keeps: assert property (
    (flag_r && !flag_w1c && !irq_vector_ack_i) |=> flag_r)
    else $error("flag lost without clear");

  chk_irq_needs_global: assert property (
    !global_irq_en_i |-> !comparator_irq_req_o)
    else $error("request without global enable");

  chk_irq_needs_enable: assert property (
    (!ien_r || !flag_r) |-> !comparator_irq_req_o)
    else $error("request without enable or flag");

  chk_rise_mode_event: assert property (
    (mode_r == ACMP_MODE_RISE && $rose(comp_sync)) |-> comp_evt)
    else $error("rising edge missed in rise mode");

  chk_reserved_mode_quiet: assert property (
    (mode_r == ACMP_MODE_RSVD) |-> !comp_evt)
    else $error("event in reserved mode");

  chk_reserved_bit_zero: assert property (
    rvalid_r |-> !rdata_r[`ACMP_B_RSV])
    else $error("reserved bit read as one");

  chk_bandgap_absent: assert property (
    !HAS_BANDGAP |-> !bg_active)
    else $error("bandgap active on variant without it");

  chk_ref_power_off: assert property (
    !(brownout_enable_fuse_i || bg_active) |=> !ref_power_r)
    else $error("reference powered with no requester");
endmodule
`default_nettype wire

// [core/acmp_params.svh]
// Offsets, field positions, reset values and timing for the comparator block
`ifndef ACMP_PARAMS_SVH
`define ACMP_PARAMS_SVH

`define ACMP_ADDR_W 8
`define ACMP_CSR_OFS 8'h00
`define ACMP_STAT_OFS 8'h04
`define ACMP_MASK_OFS 8'h08
`define ACMP_REF_OFS 8'h0c

`define ACMP_B_OFF 7
`define ACMP_B_BG 6
`define ACMP_B_RES 5
`define ACMP_B_FLAG 4
`define ACMP_B_IEN 3
`define ACMP_B_RSV 2
`define ACMP_B_STAT_CMP 0
`define ACMP_B_STAT_REF 1

`define ACMP_CSR_RST 8'h00
`define ACMP_RESP_OK 2'b00
`define ACMP_RESP_SLVERR 2'b10

`define ACMP_CLK_NS 20
`define ACMP_REF_START_NS 10000
`define ACMP_REF_START_CYC (`ACMP_REF_START_NS / `ACMP_CLK_NS)

`endif

// [core/acmp_pkg.sv]
// Types shared by the comparator control block
package acmp_pkg;
  typedef enum logic [1:0] {
    ACMP_MODE_TOGGLE = 2'b00,
    ACMP_MODE_RSVD = 2'b01,
    ACMP_MODE_FALL = 2'b10,
    ACMP_MODE_RISE = 2'b11
  } acmp_mode_type;
endpackage

// [core/acmp_sync2.sv]
// Two-stage synchroniser for single-bit levels
`timescale 1ns/1ps
`default_nettype none
module acmp_sync2 (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      meta_r <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

// [core/acmp_evdet.sv]
// Edge and toggle event detector for the synchronised comparator level
`timescale 1ns/1ps
`default_nettype none
module acmp_evdet (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic level_i,
  input wire acmp_pkg::acmp_mode_type mode_i,
  output logic event_o
);
  import acmp_pkg::*;
  logic prev_r;
  logic rise_w;
  logic fall_w;

  // Previous level, reset low like the synchroniser output
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level_i;
    end
  end

  assign rise_w = level_i & ~prev_r;
  assign fall_w = ~level_i & prev_r;

  // Event selection; the reserved code never fires
  always_comb begin
    unique case (mode_i)
      ACMP_MODE_TOGGLE: event_o = rise_w | fall_w;
      ACMP_MODE_RSVD: event_o = 1'b0;
      ACMP_MODE_FALL: event_o = fall_w;
      ACMP_MODE_RISE: event_o = rise_w;
    endcase
  end
endmodule
`default_nettype wire

// [dv/acmp_far_end.sv]
// Far-side model: comparator pins and CPU vector entry
`timescale 1ns/1ps
`default_nettype none
module acmp_far_end (
  input wire logic sys_clk_i,
  input wire logic [9:0] pos_code_i,
  input wire logic [9:0] neg_code_i,
  input wire logic irq_req_i,
  input wire logic ack_en_i,
  output logic [9:0] positive_input_o,
  output logic [9:0] negative_input_o,
  output logic irq_vector_ack_o
);
  // Pins settle one cycle after a level is asked for
  always_ff @(posedge sys_clk_i) begin
    positive_input_o <= pos_code_i;
    negative_input_o <= neg_code_i;
  end
  // One vector entry per request, never two in a row
  always_ff @(posedge sys_clk_i) begin
    irq_vector_ack_o <= ack_en_i & irq_req_i & !irq_vector_ack_o;
  end
endmodule
`default_nettype wire

// [dv/comparator_interrupt_control_test.sv]
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module comparator_interrupt_control_test;
  import acmp_pkg::*;
  localparam logic [9:0] BGC = 10'h200;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq_vector_ack_i, comparator_irq_req_o, irq_o;
  logic comp_power_o, ref_power_o;
  logic sm_ref_power;
  logic [31:0] sm_rdata, rd_sm;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [9:0] positive_input_i, negative_input_i, pc = 10'h0, nc = 10'h0;
  logic brownout_enable_fuse_i = 1'b0, global_irq_en_i = 1'b0;
  logic ack_en = 1'b0;
  int miscompares = 0, checks = 0, cyc = 0, seed = 82850;
  int m_off = 0, m_bg = 0, m_ien = 0, m_md = 0, m_flag = 0;

  always #10 sys_clk_i = ~sys_clk_i;

  acmp_top #(.BG_CODE(BGC), .REF_START_CYC(4)) uut (.sys_clk_i, .rstn_i,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .positive_input_i, .negative_input_i,
    .brownout_enable_fuse_i, .global_irq_en_i, .irq_vector_ack_i,
    .comparator_irq_req_o, .irq_o, .comp_power_o, .ref_power_o);

  acmp_far_end far (.sys_clk_i, .pos_code_i(pc), .neg_code_i(nc),
    .irq_req_i(comparator_irq_req_o), .ack_en_i(ack_en),
    .positive_input_o(positive_input_i),
    .negative_input_o(negative_input_i),
    .irq_vector_ack_o(irq_vector_ack_i));

  // Variant without the bandgap option, fed the same stimulus
  acmp_top #(.HAS_BANDGAP(1'b0), .BG_CODE(BGC), .REF_START_CYC(4)) uut_sm (
    .sys_clk_i, .rstn_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(),
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(sm_rdata),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready, .positive_input_i,
    .negative_input_i, .brownout_enable_fuse_i, .global_irq_en_i,
    .irq_vector_ack_i, .comparator_irq_req_o(), .irq_o(),
    .comp_power_o(), .ref_power_o(sm_ref_power));

  // Reference model of the control register read value
  function automatic logic [31:0] m_csr();
    int res;
    res = !m_off && ((m_bg ? int'(BGC) : int'(pc)) > int'(nc));
    return {24'h0, m_off[0], m_bg[0], res[0], m_flag[0], m_ien[0], 1'b0,
      m_md[1:0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cw(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // Write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rd_sm = sm_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Whole-word writes only, so the flag is never written back by accident
  task automatic csr_wr(input logic [7:0] v);
    axw(8'h00, {24'h0, v});
    m_off = v[7];
    m_bg = v[6];
    m_ien = v[3];
    m_md = v[1:0];
    if (v[4]) m_flag = 0;
  endtask

  task automatic csr_chk(input logic [31:0] msk);
    axr(8'h00);
    chk(rd & msk, m_csr() & msk);
  endtask

  // One level change in mode m, flag expected or not
  task automatic step(input int m, input logic [9:0] p, input int f);
    csr_wr(8'h10 | m);
    pc <= p;
    cw(6);
    m_flag = f;
    csr_chk(32'hff);
  endtask

  // Hang guard, well beyond the expected run
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    cw(10);
    rstn_i <= 1'b1;
    csr_chk(32'hff);
    chk(comp_power_o, 1'b1);
    csr_wr(8'hff);
    csr_chk(32'hff);
    chk(rd_sm & 32'h40, 32'h0);
    chk(comp_power_o, 1'b0);
    chk(ref_power_o, 1'b1);
    chk(sm_ref_power, 1'b0);
    axr(8'h10);
    chk(rd, 32'h0); // unmapped read
    chk(rs, 2'b10); // unmapped read
    axw(8'h10, 32'hff);
    chk(rs, 2'b10); // unmapped write
    $display("register test done");
    // Enable cleared in the same write that powers on, then random pin levels
    csr_wr(8'h00);
    for (int i = 0; i < 8; i++) begin
      pc <= 10'($random(seed));
      nc <= 10'($random(seed));
      cw(3);
      csr_chk(32'hef);
    end
    $display("result test done");
    pc <= 10'h010;
    nc <= 10'h100;
    cw(6);
    for (int m = 0; m < 4; m++) begin
      step(m, 10'h300, m == 0 || m == 3);
      step(m, 10'h010, m == 0 || m == 2);
    end
    $display("mode test done");
    // Request gating by flag, enable and global enable
    global_irq_en_i <= 1'b1;
    step(3, 10'h010, 0);
    csr_wr(8'h1b);
    pc <= 10'h300;
    cw(6);
    m_flag = 1;
    chk(comparator_irq_req_o, 1'b1);
    csr_wr(8'h0b);
    csr_chk(32'hff);
    global_irq_en_i <= 1'b0;
    cw(2);
    chk(comparator_irq_req_o, 1'b0);
    global_irq_en_i <= 1'b1;
    csr_wr(8'h03);
    chk(comparator_irq_req_o, 1'b0);
    csr_wr(8'h0b);
    chk(comparator_irq_req_o, 1'b1);
    ack_en <= 1'b1;
    cw(4);
    m_flag = 0;
    ack_en <= 1'b0;
    chk(comparator_irq_req_o, 1'b0);
    csr_chk(32'hff);
    step(3, 10'h010, 0);
    step(3, 10'h300, 1);
    csr_wr(8'h13);
    csr_chk(32'hff);
    $display("request test done");
    // Bandgap replaces the positive pin; allow reference start-up
    csr_wr(8'h00);
    pc <= 10'h3ff;
    csr_wr(8'h40);
    cw(10);
    csr_chk(32'hef);
    nc <= 10'h300;
    cw(6);
    m_flag = 1;
    csr_chk(32'hff);
    axr(8'h04);
    chk(rd, 32'h3);
    axw(8'h04, 32'h3);
    csr_wr(8'h00);
    cw(2);
    chk(ref_power_o, 1'b0);
    axw(8'h08, 32'h2);
    brownout_enable_fuse_i <= 1'b1;
    cw(10);
    chk(ref_power_o, 1'b1);
    axr(8'h0c);
    chk(rd, 32'h3);
    chk(irq_o, 1'b1); // ref-ready event raises the line
    axw(8'h08, 32'h0);
    chk(irq_o, 1'b0); // masked
    axw(8'h08, 32'h2);
    axw(8'h04, 32'h2);
    chk(irq_o, 1'b0); // cleared
    $display("reference test done");
    final_report();
  end
endmodule
`default_nettype wire
